/* File: design/e3tx_ovh_ctrl.v */
// e3 g.751 transmit overhead control with apb register access
`default_nettype none
`include "e3tx_consts.vh"
module e3tx_ovh_ctrl (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [13:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire in_valid,
    input wire in_data,
    input wire hdlc_bit,
    input wire far_end_alarm_ctrl_channel_n_bit,
    input wire far_end_alarm_ctrl_channel_a_bit,
    input wire rx_alarm,
    input wire oh_port_insert_en,
    input wire oh_port_data,
    input wire err_insert_mask,
    output wire hdlc_take,
    output wire far_end_alarm_ctrl_channel_n_take,
    output wire far_end_alarm_ctrl_channel_a_take,
    output wire frame_start,
    output wire out_valid,
    output wire out_data,
    output wire [15:0] err_ctrl
);
    reg [15:0] oh_ctrl_reg;
    reg [15:0] err_ctrl_reg;
    reg [31:0] rdata_reg;
    reg slverr_reg;
    reg alarm_meta_reg;
    reg alarm_sync_reg;
    reg out_valid_reg;
    reg out_data_reg;
    reg bit_next;
    wire [10:0] bit_pos;
    wire oh_pos;
    wire oh_bit;
    wire setup;
    wire sel_oh;
    wire sel_err;
    wire [1:0] n_bit_source_sel;
    wire [1:0] a_bit_source_sel;
    wire frame_gen_disable;
    wire force_alarm_all_ones;
    reg [2:0] apb_state_reg;
    reg [2:0] apb_state_next;
    reg gen_bit;
    reg ins_bit;
    reg err_bit;
    wire wr_commit;
    wire wr_oh;
    wire wr_err;
    wire addr_miss;
    wire n_slot;
    wire a_slot;
    wire [31:0] rd_word;

    // apb phase tracker, one-hot
    localparam [2:0] APB_IDLE = 3'b001;
    localparam [2:0] APB_SETUP = 3'b010;
    localparam [2:0] APB_ACCESS = 3'b100;

    function [13:0] reg_byte_addr;
        input [11:0] idx;
        begin
            reg_byte_addr = {idx, 2'b00};
        end
    endfunction

    function hits_index;
        input [13:0] addr;
        input [11:0] idx;
        begin
            hits_index = (addr == reg_byte_addr(idx));
        end
    endfunction

    function slot_at;
        input [10:0] pos;
        input [10:0] slot;
        begin
            slot_at = (pos == slot);
        end
    endfunction

    function [15:0] field_mask;
        input [15:0] data;
        input [15:0] mask;
        begin
            field_mask = data & mask;
        end
    endfunction

    function [31:0] read_word;
        input hit_oh;
        input hit_err;
        input [15:0] oh_val;
        input [15:0] err_val;
        begin
            read_word = 32'h00000000;
            if (hit_oh) begin
                read_word = {16'h0000, oh_val};
            end else if (hit_err) begin
                read_word = {16'h0000, err_val};
            end
        end
    endfunction

    function take_strobe;
        input valid;
        input gen_off;
        input at_slot;
        input [1:0] sel;
        input [1:0] code;
        begin
            take_strobe = valid && !gen_off && at_slot && (sel == code);
        end
    endfunction

    assign n_bit_source_sel = oh_ctrl_reg[`E3TX_NSEL_HI:`E3TX_NSEL_LO];
    assign a_bit_source_sel = oh_ctrl_reg[`E3TX_ASEL_HI:`E3TX_ASEL_LO];
    assign frame_gen_disable = oh_ctrl_reg[`E3TX_FGD_BIT];
    assign force_alarm_all_ones = oh_ctrl_reg[`E3TX_AIS_BIT];

    // apb: zero wait states, the response is latched in the setup cycle
    assign setup = psel && !penable;
    assign sel_oh = hits_index(paddr, `E3TX_IDX_OH_CTRL);
    assign sel_err = hits_index(paddr, `E3TX_IDX_ERR_CTRL);
    assign addr_miss = !(sel_oh || sel_err);
    assign rd_word = read_word(!pwrite && sel_oh, !pwrite && sel_err, oh_ctrl_reg, err_ctrl_reg);
    assign n_slot = slot_at(bit_pos, `E3TX_N_POS);
    assign a_slot = slot_at(bit_pos, `E3TX_A_POS);
    assign pready = 1'b1;
    assign prdata = rdata_reg;
    assign pslverr = slverr_reg;

    // a write lands only in an access that follows its own setup, so a
    // stray penable without a setup cannot disturb the registers
    always @* begin
        apb_state_next = APB_IDLE;
        case (apb_state_reg)
            APB_IDLE: begin
                if (psel && !penable) begin
                    apb_state_next = APB_SETUP;
                end
            end
            APB_SETUP: begin
                if (psel && penable) begin
                    apb_state_next = APB_ACCESS;
                end else if (psel) begin
                    apb_state_next = APB_SETUP;
                end
            end
            APB_ACCESS: begin
                if (psel && !penable) begin
                    apb_state_next = APB_SETUP;
                end
            end
            default: begin
                apb_state_next = APB_IDLE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_state_reg <= APB_IDLE;
        end else begin
            apb_state_reg <= apb_state_next;
        end
    end

    assign wr_commit = (apb_state_reg == APB_SETUP) && psel && penable && pwrite;
    assign wr_oh = wr_commit && sel_oh;
    assign wr_err = wr_commit && sel_err;

    // reserved bits stay zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oh_ctrl_reg <= `E3TX_OH_CTRL_RST;
        end else if (wr_oh) begin
            oh_ctrl_reg <= field_mask(pwdata[15:0], `E3TX_OH_CTRL_MASK);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_ctrl_reg <= `E3TX_ERR_CTRL_RST;
        end else if (wr_err) begin
            err_ctrl_reg <= field_mask(pwdata[15:0], `E3TX_ERR_CTRL_MASK);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slverr_reg <= 1'b0;
        end else if (setup) begin
            slverr_reg <= addr_miss;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h00000000;
        end else if (setup) begin
            rdata_reg <= rd_word;
        end
    end

    // received alarm comes from another part of the chip, resynchronised first
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_meta_reg <= 1'b0;
            alarm_sync_reg <= 1'b0;
        end else begin
            alarm_meta_reg <= rx_alarm;
            alarm_sync_reg <= alarm_meta_reg;
        end
    end

    e3tx_frame_cnt u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .bit_valid(in_valid),
        .bit_pos(bit_pos),
        .frame_start(frame_start)
    );

    e3tx_oh_sel u_sel (
        .bit_pos(bit_pos),
        .n_bit_source_sel(n_bit_source_sel),
        .a_bit_source_sel(a_bit_source_sel),
        .hdlc_bit(hdlc_bit),
        .far_end_alarm_ctrl_channel_n_bit(far_end_alarm_ctrl_channel_n_bit),
        .far_end_alarm_ctrl_channel_a_bit(far_end_alarm_ctrl_channel_a_bit),
        .rx_alarm(alarm_sync_reg),
        .oh_pos(oh_pos),
        .oh_bit(oh_bit)
    );

    // consume strobes tell each source its bit was used; far_end_alarm_ctrl_channel n and a are
    // taken separately so the two bits of one frame need not match
    assign hdlc_take = take_strobe(in_valid, frame_gen_disable, n_slot,
        n_bit_source_sel, `E3TX_NSEL_HDLC);
    assign far_end_alarm_ctrl_channel_n_take = take_strobe(in_valid, frame_gen_disable, n_slot,
        n_bit_source_sel, `E3TX_NSEL_FAR_END_ALARM_CTRL_CHANNEL);
    assign far_end_alarm_ctrl_channel_a_take = take_strobe(in_valid, frame_gen_disable, a_slot,
        a_bit_source_sel, `E3TX_ASEL_FAR_END_ALARM_CTRL_CHANNEL);

    // one stage per source so the override order stays easy to audit:
    // generated, then port insertion, then error mask, then all-ones
    always @* begin
        gen_bit = in_data;
        if (oh_pos && !frame_gen_disable) begin
            gen_bit = oh_bit;
        end
    end

    always @* begin
        ins_bit = gen_bit;
        if (oh_pos && oh_port_insert_en) begin
            ins_bit = oh_port_data;
        end
    end

    always @* begin
        err_bit = ins_bit ^ err_insert_mask;
    end

    always @* begin
        bit_next = err_bit;
        if (force_alarm_all_ones) begin
            bit_next = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_reg <= 1'b0;
        end else begin
            out_valid_reg <= in_valid;
        end
    end

    // holds the last bit between valid cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_data_reg <= 1'b0;
        end else if (in_valid) begin
            out_data_reg <= bit_next;
        end
    end

    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;
    assign err_ctrl = err_ctrl_reg;
endmodule // e3tx_ovh_ctrl
`default_nettype wire

/* File: design/e3tx_consts.vh */
// constants for the e3 g.751 transmit overhead control block
`ifndef E3TX_CONSTS_VH
`define E3TX_CONSTS_VH
`define E3TX_IDX_OH_CTRL 12'h118
`define E3TX_IDX_ERR_CTRL 12'h11a
`define E3TX_ADDR_W 12
`define E3TX_OH_CTRL_RST 16'h0000
`define E3TX_ERR_CTRL_RST 16'h0000
`define E3TX_OH_CTRL_MASK 16'h030f
`define E3TX_ERR_CTRL_MASK 16'h001f
`define E3TX_NSEL_HI 9
`define E3TX_NSEL_LO 8
`define E3TX_ASEL_HI 3
`define E3TX_ASEL_LO 2
`define E3TX_FGD_BIT 1
`define E3TX_AIS_BIT 0
`define E3TX_NSEL_ONE 2'h0
`define E3TX_NSEL_HDLC 2'h1
`define E3TX_NSEL_FAR_END_ALARM_CTRL_CHANNEL 2'h2
`define E3TX_NSEL_ZERO 2'h3
`define E3TX_ASEL_AUTO 2'h0
`define E3TX_ASEL_FAR_END_ALARM_CTRL_CHANNEL 2'h1
`define E3TX_ASEL_ZERO 2'h2
`define E3TX_ASEL_ONE 2'h3
`define E3TX_FRAME_LEN 11'h600
`define E3TX_FAS_LEN 11'h00a
`define E3TX_A_POS 11'h00a
`define E3TX_N_POS 11'h00b
`define E3TX_FAS_PATTERN 10'h3d0
`endif

/* File: design/e3tx_frame_cnt.v */
// frame bit position counter for the transmit stream
`default_nettype none
`include "e3tx_consts.vh"
module e3tx_frame_cnt (
    input wire pclk,
    input wire presetn,
    input wire bit_valid,
    output wire [10:0] bit_pos,
    output wire frame_start
);
    reg [10:0] pos_reg;
    wire [10:0] pos_next;
    assign pos_next = (pos_reg == (`E3TX_FRAME_LEN - 11'h001)) ? 11'h000 : pos_reg + 11'h001;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_reg <= 11'h000;
        end else if (bit_valid) begin
            pos_reg <= pos_next;
        end
    end
    assign bit_pos = pos_reg;
    assign frame_start = bit_valid && (pos_reg == 11'h000);
endmodule // e3tx_frame_cnt
`default_nettype wire

/* File: design/e3tx_oh_sel.v */
// selects the generated overhead bit for the current frame position
`default_nettype none
`include "e3tx_consts.vh"
module e3tx_oh_sel (
    input wire [10:0] bit_pos,
    input wire [1:0] n_bit_source_sel,
    input wire [1:0] a_bit_source_sel,
    input wire hdlc_bit,
    input wire far_end_alarm_ctrl_channel_n_bit,
    input wire far_end_alarm_ctrl_channel_a_bit,
    input wire rx_alarm,
    output reg oh_pos,
    output reg oh_bit
);
    reg [3:0] fas_idx;
    reg [9:0] fas_word;
    always @* begin
        fas_idx = bit_pos[3:0];
        fas_word = `E3TX_FAS_PATTERN;
        oh_pos = 1'b1;
        oh_bit = 1'b0;
        if (bit_pos < `E3TX_FAS_LEN) begin
            oh_bit = fas_word[4'h9 - fas_idx];
        end else if (bit_pos == `E3TX_A_POS) begin
            case (a_bit_source_sel)
                `E3TX_ASEL_AUTO: oh_bit = rx_alarm;
                `E3TX_ASEL_FAR_END_ALARM_CTRL_CHANNEL: oh_bit = far_end_alarm_ctrl_channel_a_bit;
                `E3TX_ASEL_ZERO: oh_bit = 1'b0;
                default: oh_bit = 1'b1;
            endcase
        end else if (bit_pos == `E3TX_N_POS) begin
            case (n_bit_source_sel)
                `E3TX_NSEL_ONE: oh_bit = 1'b1;
                `E3TX_NSEL_HDLC: oh_bit = hdlc_bit;
                `E3TX_NSEL_FAR_END_ALARM_CTRL_CHANNEL: oh_bit = far_end_alarm_ctrl_channel_n_bit;
                default: oh_bit = 1'b0;
            endcase
        end else begin
            oh_pos = 1'b0;
        end
    end
endmodule // e3tx_oh_sel
`default_nettype wire

/* File: tb/e3tx_chk_sva.sv */
// assertions on the transmit overhead block ports
`default_nettype none
module e3tx_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic in_valid,
    input wire logic in_data,
    input wire logic hdlc_bit,
    input wire logic far_end_alarm_ctrl_channel_n_bit,
    input wire logic oh_port_insert_en,
    input wire logic oh_port_data,
    input wire logic err_insert_mask,
    input wire logic hdlc_take,
    input wire logic far_end_alarm_ctrl_channel_n_take,
    input wire logic out_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] ctl;
    logic [10:0] pos;
    // shadow copies, since the control register is not visible at the ports
    wire ok = in_valid && !ctl[0] && !oh_port_insert_en && !err_insert_mask;
    wire oh = pos < 11'h00c;
    wire n = ok && !ctl[1] && pos == 11'h00b;
    wire a = ok && !ctl[1] && pos == 11'h00a;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= 16'h0000;
            pos <= 11'h000;
        end else begin
            if (psel && penable && pwrite && paddr == 14'h0460) ctl <= pwdata[15:0];
            if (in_valid) pos <= (pos == 11'h5ff) ? 11'h000 : pos + 11'h001;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_n_one: assert property (n && ctl[9:8] == 2'h0 |=> out_data) else $error("n one");
    a_n_zero: assert property (n && ctl[9:8] == 2'h3 |=> !out_data) else $error("n zero");
    a_n_hdlc: assert property (n && ctl[9:8] == 2'h1 |-> hdlc_take ##1 out_data == $past(hdlc_bit)) else $error("n");
    a_n_far_end_alarm_ctrl_channel: assert property (n && ctl[9:8] == 2'h2 |-> far_end_alarm_ctrl_channel_n_take ##1 out_data == $past(far_end_alarm_ctrl_channel_n_bit)) else $error("n");
    a_a_fixed: assert property (a && ctl[3] |=> out_data == $past(ctl[2])) else $error("a fixed");
    a_gen_off: assert property (ok && ctl[1] && oh |-> !hdlc_take && !far_end_alarm_ctrl_channel_n_take ##1 out_data == $past(in_data))
        else $error("gen off");
    a_mask_over: assert property (ctl[1] && !ctl[0] && in_valid && oh && err_insert_mask && oh_port_insert_en
        |=> out_data != $past(oh_port_data)) else $error("insert");
    a_ais_ones: assert property (in_valid && ctl[0] |=> out_data) else $error("ais");
endmodule // e3tx_chk
bind e3tx_ovh_ctrl e3tx_chk chk_u (.*);
`default_nettype wire

/* File: tb/e3tx_src.sv */
// upstream payload and overhead source model
`default_nettype none
module e3tx_src (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    output logic in_valid,
    output logic in_data,
    output logic hdlc_bit,
    output logic far_end_alarm_ctrl_channel_n_bit,
    output logic far_end_alarm_ctrl_channel_a_bit
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt <= 8'h00;
        else cnt <= cnt + 8'h01;
    end
    // lines keep changing as the counter runs so a stale bit is never taken for a fresh one
    assign in_valid = !slow || cnt[1];
    assign in_data = cnt[0] ^ cnt[2];
    assign hdlc_bit = cnt[0] ^ cnt[3];
    assign far_end_alarm_ctrl_channel_n_bit = cnt[1] ^ cnt[4];
    assign far_end_alarm_ctrl_channel_a_bit = ~cnt[0] ^ cnt[5];
endmodule // e3tx_src
`default_nettype wire

/* File: tb/e3tx_ovh_ctrl_bench.sv */
// self-checking bench for the transmit overhead block
`default_nettype none
module e3tx_ovh_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, slow = 1'h1;
    logic rx = 1'h1, port_en = 1'h0, mask = 1'h0, pd = 1'h0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [15:0] err_ctrl;
    logic pready, pslverr, iv, id, hb, fnb, fab, fs, od, fat, ov;
    int err_count = 0, checks_done = 0;
    always #25 pclk = ~pclk;
    e3tx_src src_u (.pclk(pclk), .presetn(presetn), .slow(slow), .in_valid(iv), .in_data(id), .hdlc_bit(hb),
        .far_end_alarm_ctrl_channel_n_bit(fnb), .far_end_alarm_ctrl_channel_a_bit(fab));
    e3tx_ovh_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(iv),
        .in_data(id), .hdlc_bit(hb), .far_end_alarm_ctrl_channel_n_bit(fnb), .far_end_alarm_ctrl_channel_a_bit(fab), .rx_alarm(rx), .oh_port_insert_en(port_en),
        .oh_port_data(pd), .err_insert_mask(mask), .hdlc_take(), .far_end_alarm_ctrl_channel_n_take(), .far_end_alarm_ctrl_channel_a_take(fat),
        .frame_start(fs), .out_valid(ov), .out_data(od), .err_ctrl(err_ctrl));
    task ck(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [13:0] a, input logic [31:0] d, output logic [31:0] r, output logic s);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        r = prdata;
        s = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // m: 0 selected sources, 1 payload passed, 2 forced one
    task frm(input logic [1:0] ns, input logic [1:0] as, input logic [1:0] m);
        logic e;
        do begin
            @(posedge pclk);
            #1;
        end while (fs !== 1'h1);
        repeat (10) @(posedge pclk);
        #1;
        e = m[1] | (m[0] ? id : as == 2'h1 ? fab : as == 2'h0 ? rx : as[0]);
        ck(fat, m == 2'h0 && as == 2'h1);
        @(posedge pclk);
        #1;
        ck(od, e);
        ck(ov, 1'h1);
        e = m[1] | (m[0] ? id : ns == 2'h1 ? hb : ns == 2'h2 ? fnb : ns == 2'h0);
        @(posedge pclk);
        #1;
        ck(od, e);
    endtask
    task t_regs;
        logic [31:0] r;
        logic s;
        apb(1'h0, 14'h0460, 32'h00000000, r, s);
        ck(r, 32'h00000000);
        apb(1'h1, 14'h0460, 32'hffffffff, r, s);
        apb(1'h0, 14'h0460, 32'h00000000, r, s);
        ck(r, 32'h0000030f);
        apb(1'h1, 14'h0468, 32'hffffffff, r, s);
        apb(1'h0, 14'h0468, 32'h00000000, r, s);
        ck(r, 32'h0000001f);
        ck(err_ctrl, 32'h0000001f);
        apb(1'h0, 14'h0464, 32'h00000000, r, s);
        ck({r[30:0], s}, 32'h00000001);
    endtask
    task t_src;
        logic [31:0] r;
        logic s;
        slow <= 1'h0;
        rx <= 1'h0;
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, 14'h0460, {22'h000000, i[1:0], 4'h0, ~i[1:0], 2'h0}, r, s);
            frm(i[1:0], ~i[1:0], 2'h0);
        end
    endtask
    task t_off;
        logic [31:0] r;
        logic s;
        apb(1'h1, 14'h0460, 32'h00000002, r, s);
        frm(2'h0, 2'h0, 2'h1);
        @(posedge pclk);
        pd <= 1'h1;
        port_en <= 1'h1;
        frm(2'h0, 2'h0, 2'h2);
        @(posedge pclk);
        pd <= 1'h0;
        mask <= 1'h1;
        frm(2'h0, 2'h0, 2'h2);
    endtask
    task t_ais;
        logic [31:0] r;
        logic s;
        @(posedge pclk);
        mask <= 1'h0;
        port_en <= 1'h0;
        apb(1'h1, 14'h0460, 32'h00000001, r, s);
        frm(2'h0, 2'h0, 2'h2);
    endtask
    task stop_test;
        if (err_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        t_regs;
        t_src;
        t_off;
        t_ais;
        stop_test;
    end
    initial begin
        #3000000;
        err_count++;
        stop_test;
    end
endmodule // e3tx_ovh_ctrl_bench
`default_nettype wire
